// ### include/trig_route_pkg.sv
// Purpose: constants and carriers for the trigger routing block
// Assumes: 50 MHz system clock, four slot channels in two sensor pairs
// Notes:   register addresses are word indices on the plain register port
package trig_route_pkg;

   localparam int          NCH        = 4;
   localparam int          AW         = 4;
   localparam int          DW         = 32;

   // register addresses
   localparam logic [3:0]  ADDR_SEL0  = 4'h0;
   localparam logic [3:0]  ADDR_CONN  = 4'h4;
   localparam logic [3:0]  ADDR_FOOT  = 4'h5;
   localparam logic [3:0]  ADDR_CTRL  = 4'h6;
   localparam logic [3:0]  ADDR_DUAL  = 4'h7;
   localparam logic [3:0]  ADDR_STAT  = 4'h8;

   // channel register fields
   localparam int          SEL_LSB    = 0;
   localparam int          REARM_BIT  = 8;
   localparam int          ARMED_BIT  = 16;
   // connector register fields
   localparam int          MODE_LSB   = 0;
   localparam int          CUSTOM_BIT = 4;
   // control register: return to local
   localparam int          LOCAL_BIT  = 0;

   // output event selector codes
   localparam logic [2:0]  SEL_NEVER      = 3'h0;
   localparam logic [2:0]  SEL_AVG_END    = 3'h1;
   localparam logic [2:0]  SEL_AVG_START  = 3'h2;
   localparam logic [2:0]  SEL_EDGE_A     = 3'h3;
   localparam logic [2:0]  SEL_STEP_DONE  = 3'h4;
   localparam logic [2:0]  SEL_SWEEP_DONE = 3'h5;
   localparam logic [2:0]  SEL_SWEEP_GO   = 3'h6;

   // connector modes and custom readback code
   localparam logic [1:0]  MODE_OFF   = 2'h0;
   localparam logic [1:0]  MODE_DEF   = 2'h1;
   localparam logic [1:0]  MODE_FWD   = 2'h2;
   localparam logic [1:0]  MODE_LOOP  = 2'h3;
   localparam logic [2:0]  MODE_CUSTOM_RD = 3'h4;

   // values after reset
   localparam logic [2:0]  SEL_RST    = SEL_NEVER;
   localparam logic        REARM_DEF  = 1'b1;
   localparam logic [1:0]  MODE_RST   = MODE_DEF;
   localparam logic        FOOT_RST   = 1'b0;
   localparam logic [1:0]  DUAL_RST   = 2'h0;

   // per-channel event sources from the slot module, same clock
   typedef struct packed {
      logic avg_end;
      logic avg_start;
      logic step_done;
      logic sweep_done;
      logic sweep_start;
      logic continuous;
      logic width_tick;
   } chan_evt_s;

   // register port request
   typedef struct packed {
      logic          wr;
      logic          rd;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
   } reg_req_s;

endpackage : trig_route_pkg

// ### src/trigger_routing_config.sv
// Purpose: per-slot output trigger selection and connector routing
// Assumes: slot events are one-cycle pulses on clk; pins are asynchronous
// Notes:   read data stands in the cycle after the read strobe only
//
// The implementer's own choices: strobed register access and the placing of the registers.

module trigger_routing_config
(
   input  wire logic                                    clk,
   input  wire logic                                    rst_n,
   input  wire trig_route_pkg::reg_req_s                req,
   output logic [trig_route_pkg::DW-1:0]                rdata,
   input  wire trig_route_pkg::chan_evt_s [trig_route_pkg::NCH-1:0] evt,
   input  wire logic [trig_route_pkg::NCH-1:0]          ttl_mod,
   input  wire logic                                    trig_in_pin,
   input  wire logic                                    pedal_pin,
   output logic                                         trig_out_pin,
   output logic                                         slot_in_trig,
   output logic [trig_route_pkg::NCH-1:0]               chan_fire
);

   localparam int N = trig_route_pkg::NCH;

   typedef struct packed {
      logic [N-1:0][2:0]               sel;
      logic [N-1:0]                    rearm;
      logic [N-1:0]                    armed;
      logic [1:0]                      mode;
      logic                            custom;
      logic                            foot;
      logic [1:0]                      dual;
      logic [N-1:0]                    ttl_s1;
      logic [N-1:0]                    ttl_s2;
      logic [N-1:0]                    ttl_p;
      logic                            tin_s1;
      logic                            tin_s2;
      logic                            tin_p;
      logic                            ped_s1;
      logic                            ped_s2;
      logic                            ped_p;
      logic [N-1:0]                    fire;
      logic                            trig_out;
      logic                            slot_in;
      logic [trig_route_pkg::DW-1:0]   rdata;
   } state_s;

   state_s q;
   state_s n;

   // event chosen by a channel selector
   function automatic logic chan_event
   (
      input logic [2:0]                sel,
      input trig_route_pkg::chan_evt_s e,
      input logic                      ttl_rise
   );
      case (sel)
         trig_route_pkg::SEL_AVG_END:    chan_event = e.avg_end;
         trig_route_pkg::SEL_AVG_START:  chan_event = e.avg_start;
         trig_route_pkg::SEL_EDGE_A:     chan_event = ttl_rise;
         trig_route_pkg::SEL_STEP_DONE:
            chan_event = e.continuous ? e.width_tick : e.step_done;
         trig_route_pkg::SEL_SWEEP_DONE: chan_event = e.sweep_done;
         trig_route_pkg::SEL_SWEEP_GO:   chan_event = e.sweep_start;
         default:                        chan_event = 1'b0;
      endcase
   endfunction : chan_event

   // odd channel of an enabled pair takes no writes
   function automatic logic is_slave
   (
      input logic [1:0] ch,
      input logic [1:0] dual
   );
      is_slave = ch[0] & dual[ch[1]];
   endfunction : is_slave

   always_comb
   begin
      logic [N-1:0] ttl_rise;
      logic         in_rise;
      logic         conn_on;
      logic         in_evt;
      logic         any_fire;
      logic [1:0]   ch;
      logic [1:0]   sl;
      ttl_rise = '0;
      in_rise  = 1'b0;
      conn_on  = 1'b0;
      in_evt   = 1'b0;
      any_fire = 1'b0;
      ch       = req.addr[1:0];
      sl       = {ch[1], 1'b1};
      n        = q;
      n.rdata    = '0;
      n.fire     = '0;
      n.trig_out = 1'b0;
      n.slot_in  = 1'b0;

      // pin synchronisers
      n.ttl_s1 = ttl_mod;
      n.ttl_s2 = q.ttl_s1;
      n.ttl_p  = q.ttl_s2;
      n.tin_s1 = trig_in_pin;
      n.tin_s2 = q.tin_s1;
      n.tin_p  = q.tin_s2;
      n.ped_s1 = pedal_pin;
      n.ped_s2 = q.ped_s1;
      n.ped_p  = q.ped_s2;
      ttl_rise = q.ttl_s2 & ~q.ttl_p;

      // channel output events
      for (int i = 0; i < N; i++)
      begin
         if (q.armed[i] && chan_event(q.sel[i], evt[i], ttl_rise[i]))
         begin
            n.fire[i] = 1'b1;
            if (!q.rearm[i])
            begin
               n.armed[i] = 1'b0;
            end
         end
      end
      any_fire = |n.fire;

      // connector routing
      in_rise = (q.tin_s2 & ~q.tin_p)
              | (q.foot & q.ped_s2 & ~q.ped_p);
      conn_on = (q.mode != trig_route_pkg::MODE_OFF) && !q.custom;
      in_evt  = conn_on && in_rise;
      n.trig_out = conn_on && (any_fire
                 || (q.mode == trig_route_pkg::MODE_FWD && in_evt));
      // loop feeds slots only, never back to the output
      n.slot_in  = in_evt || (conn_on
                 && q.mode == trig_route_pkg::MODE_LOOP && any_fire);

      // register writes, applied after firing so arming wins
      if (req.wr)
      begin
         if (req.addr[3:2] == trig_route_pkg::ADDR_SEL0[3:2])
         begin
            if (!is_slave(ch, q.dual))
            begin
               n.sel[ch]   = req.wdata[trig_route_pkg::SEL_LSB +: 3];
               n.rearm[ch] = req.wdata[trig_route_pkg::REARM_BIT];
               n.armed[ch] = 1'b1;
               if (!ch[0] && q.dual[ch[1]])
               begin
                  n.sel[sl]   = n.sel[ch];
                  n.rearm[sl] = n.rearm[ch];
                  n.armed[sl] = 1'b1;
               end
            end
         end
         else
         begin
            case (req.addr)
               trig_route_pkg::ADDR_CONN:
               begin
                  n.mode   = req.wdata[trig_route_pkg::MODE_LSB +: 2];
                  n.custom = req.wdata[trig_route_pkg::CUSTOM_BIT];
               end
               trig_route_pkg::ADDR_FOOT:
                  n.foot = req.wdata[0];
               trig_route_pkg::ADDR_CTRL:
               begin
                  if (req.wdata[trig_route_pkg::LOCAL_BIT])
                  begin
                     n.rearm = {N{trig_route_pkg::REARM_DEF}};
                  end
               end
               trig_route_pkg::ADDR_DUAL:
                  n.dual = req.wdata[1:0];
               default:
                  n.dual = q.dual;
            endcase
         end
      end

      // register reads
      if (req.rd)
      begin
         if (req.addr[3:2] == trig_route_pkg::ADDR_SEL0[3:2])
         begin
            n.rdata[trig_route_pkg::SEL_LSB +: 3]   = q.sel[ch];
            n.rdata[trig_route_pkg::REARM_BIT]      = q.rearm[ch];
            n.rdata[trig_route_pkg::ARMED_BIT]      = q.armed[ch];
         end
         else
         begin
            case (req.addr)
               trig_route_pkg::ADDR_CONN:
                  n.rdata[2:0] = q.custom ? trig_route_pkg::MODE_CUSTOM_RD
                                          : {1'b0, q.mode};
               trig_route_pkg::ADDR_FOOT:
                  n.rdata[0] = q.foot;
               trig_route_pkg::ADDR_DUAL:
                  n.rdata[1:0] = q.dual;
               trig_route_pkg::ADDR_STAT:
                  n.rdata[N-1:0] = q.armed;
               default:
                  n.rdata = '0;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q       <= '0;
         q.sel   <= {N{trig_route_pkg::SEL_RST}};
         q.rearm <= {N{trig_route_pkg::REARM_DEF}};
         q.mode  <= trig_route_pkg::MODE_RST;
         q.foot  <= trig_route_pkg::FOOT_RST;
         q.dual  <= trig_route_pkg::DUAL_RST;
      end
      else
      begin
         q <= n;
      end
   end

   assign rdata        = q.rdata;
   assign trig_out_pin = q.trig_out;
   assign slot_in_trig = q.slot_in;
   assign chan_fire    = q.fire;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_sel_wr0;
      req.wr && req.addr == trig_route_pkg::ADDR_SEL0;
   endsequence

   sequence s_loop_out;
      q.mode == trig_route_pkg::MODE_LOOP && !q.custom ##1 q.trig_out;
   endsequence

   a_write_arms: assert property (s_sel_wr0 |=> q.armed[0])
      else $error("selector write did not arm channel");
   a_never_silent: assert property (
      q.sel[0] == trig_route_pkg::SEL_NEVER |=> !q.fire[0])
      else $error("never selector fired");
   a_avg_end_fire: assert property (
      q.sel[0] == trig_route_pkg::SEL_AVG_END && q.armed[0]
      && evt[0].avg_end |=> q.fire[0])
      else $error("averaging end missed");
   a_avg_start_fire: assert property (
      q.sel[0] == trig_route_pkg::SEL_AVG_START && q.armed[0]
      && evt[0].avg_start |=> q.fire[0])
      else $error("averaging start missed");
   a_edge_fire: assert property (
      q.sel[0] == trig_route_pkg::SEL_EDGE_A && q.armed[0]
      && q.ttl_s2[0] && !q.ttl_p[0] |=> q.fire[0])
      else $error("edge_a edge missed");
   a_cont_step: assert property (
      q.sel[0] == trig_route_pkg::SEL_STEP_DONE && q.armed[0]
      && evt[0].continuous |=> q.fire[0] == $past(evt[0].width_tick))
      else $error("continuous step trigger wrong");
   a_rearm_off: assert property (
      q.fire[0] && !$past(q.rearm[0])
      && !$past(req.wr) |-> !q.armed[0])
      else $error("channel stayed armed without rearm");
   a_local_default: assert property (
      req.wr && req.addr == trig_route_pkg::ADDR_CTRL
      && req.wdata[trig_route_pkg::LOCAL_BIT]
      |=> q.rearm == {N{trig_route_pkg::REARM_DEF}})
      else $error("local return kept rearm");
   a_slave_locked: assert property (
      q.dual[0] && req.wr && req.addr == 4'h1 |=> $stable(q.sel[1]))
      else $error("slave channel took a write");
   a_mode_off: assert property (
      q.mode == trig_route_pkg::MODE_OFF |=> !q.trig_out && !q.slot_in)
      else $error("disabled connectors passed a trigger");
   a_forward_in: assert property (
      q.mode == trig_route_pkg::MODE_FWD && !q.custom
      && q.tin_s2 && !q.tin_p |=> q.trig_out ##0 q.slot_in)
      else $error("input not forwarded");
   a_loop_back: assert property (s_loop_out |-> q.slot_in)
      else $error("output not looped to input");
   a_no_echo: assert property (
      q.trig_out |-> (|q.fire)
      || $past(q.mode) == trig_route_pkg::MODE_FWD)
      else $error("trigger echoed to output");

   sequence s_def_fire;
      q.mode == trig_route_pkg::MODE_DEF && !q.custom ##1 q.fire[0];
   endsequence

   sequence s_in_rise;
      q.tin_s2 && !q.tin_p;
   endsequence

   a_step_fire: assert property (
      q.sel[0] == trig_route_pkg::SEL_STEP_DONE && q.armed[0]
      && !evt[0].continuous && evt[0].step_done |=> q.fire[0])
      else $error("step finished missed");
   a_sweep_done: assert property (
      q.sel[0] == trig_route_pkg::SEL_SWEEP_DONE && q.armed[0]
      && evt[0].sweep_done |=> q.fire[0])
      else $error("sweep finished missed");
   a_sweep_start: assert property (
      q.sel[0] == trig_route_pkg::SEL_SWEEP_GO && q.armed[0]
      && evt[0].sweep_start |=> q.fire[0])
      else $error("sweep start missed");
   a_reset_state: assert property (
      $rose(rst_n) |-> q.rearm == {N{trig_route_pkg::REARM_DEF}}
      && q.armed == '0 && q.mode == trig_route_pkg::MODE_RST)
      else $error("wrong state after reset");
   a_dual_mirror: assert property (
      s_sel_wr0 ##0 q.dual[0] |=> q.sel[1] == q.sel[0]
      && q.rearm[1] == q.rearm[0] && q.armed[1])
      else $error("slave channel did not mirror");
   a_def_out: assert property (s_def_fire |-> q.trig_out)
      else $error("slot event missed output connector");
   a_in_pulse: assert property (
      q.mode == trig_route_pkg::MODE_DEF && !q.custom && !q.foot
      && !req.wr ##0 s_in_rise |=> q.slot_in ##1 !q.slot_in)
      else $error("input trigger not a single pulse");
   a_custom_quiet: assert property (
      q.custom |=> !q.trig_out && !q.slot_in)
      else $error("custom routing drove a connector");
   a_custom_read: assert property (
      req.rd && req.addr == trig_route_pkg::ADDR_CONN && q.custom
      |=> q.rdata[2:0] == trig_route_pkg::MODE_CUSTOM_RD)
      else $error("custom not reported");
   a_pedal_off: assert property (
      q.mode == trig_route_pkg::MODE_DEF && !q.foot
      && !(q.tin_s2 && !q.tin_p) |=> !q.slot_in)
      else $error("pedal passed while disabled");
   a_pedal_on: assert property (
      q.mode == trig_route_pkg::MODE_DEF && !q.custom && q.foot
      && q.ped_s2 && !q.ped_p |=> q.slot_in)
      else $error("enabled pedal missed");

endmodule : trigger_routing_config

// ### tb/ext_instrument.sv
// Purpose: external equipment on the trigger and pedal connectors
// Assumes: pins are driven low when idle, pulses held a few cycles
// Notes:   counts output connector pulses it receives
module ext_instrument
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic fire_in,
   input  wire logic fire_pedal,
   input  wire logic trig_out_pin,
   output logic      trig_in_pin,
   output logic      pedal_pin,
   output int        seen
);
   timeunit 1ns;
   timeprecision 1ps;
   int hold_in;
   int hold_ped;

   // pins rise, stay high four cycles, then fall for a new edge
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hold_in  <= 0;
         hold_ped <= 0;
         seen     <= 0;
      end
      else
      begin
         hold_in  <= fire_in ? 4 : (hold_in > 0 ? hold_in - 1 : 0);
         hold_ped <= fire_pedal ? 4 : (hold_ped > 0 ? hold_ped - 1 : 0);
         if (trig_out_pin === 1'b1)
            seen <= seen + 1;
      end
   end
   assign trig_in_pin = (hold_in > 0);
   assign pedal_pin   = (hold_ped > 0);
endmodule : ext_instrument

// ### tb/testbench.sv
// Purpose: self-checking bench for the trigger routing block
// Assumes: 50 MHz clock, register port read data one cycle after strobe
// Notes:   pulse counts sum high cycles, so stretched pulses show up
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic                              clk;
   logic                              rst_n;
   trig_route_pkg::reg_req_s          req;
   logic [trig_route_pkg::DW-1:0]     rdata;
   trig_route_pkg::chan_evt_s [3:0]   evt;
   logic [3:0]                        ttl_mod;
   logic                              trig_in_pin;
   logic                              pedal_pin;
   logic                              trig_out_pin;
   logic                              slot_in_trig;
   logic [3:0]                        chan_fire;
   logic                              fire_in;
   logic                              fire_pedal;
   int                                seen;
   int                                n_mismatch;
   int                                n_tests;
   int                                n_fire;
   int                                n_slot;
   int                                n_fire1;
   int                                seen0;
   logic [31:0]                       rd_v;
   logic [3:0]                        mode_tbl [4];

   trigger_routing_config dut (.clk(clk), .rst_n(rst_n), .req(req),
      .rdata(rdata), .evt(evt), .ttl_mod(ttl_mod),
      .trig_in_pin(trig_in_pin), .pedal_pin(pedal_pin),
      .trig_out_pin(trig_out_pin), .slot_in_trig(slot_in_trig),
      .chan_fire(chan_fire));
   ext_instrument peer (.clk(clk), .rst_n(rst_n), .fire_in(fire_in),
      .fire_pedal(fire_pedal), .trig_out_pin(trig_out_pin),
      .trig_in_pin(trig_in_pin), .pedal_pin(pedal_pin), .seen(seen));

   always #10 clk = ~clk;

   always @(posedge clk)
   begin
      if (chan_fire[0] === 1'b1)
         n_fire++;
      if (chan_fire[1] === 1'b1)
         n_fire1++;
      if (slot_in_trig === 1'b1)
         n_slot++;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge clk);
      req.rd <= 1'b0;
      @(negedge clk);
      rd_v = rdata;
   endtask : rd

   // one source: 0 avg_end 1 avg_start 2 ttl 3 step 4 sweep end 5 start
   // 6 width tick, then clear the events and let them settle
   task automatic stim(input int k);
      @(posedge clk);
      case (k)
         0: evt[0].avg_end <= 1'b1;
         1: evt[0].avg_start <= 1'b1;
         2: ttl_mod[0] <= 1'b1;
         3: evt[0].step_done <= 1'b1;
         4: evt[0].sweep_done <= 1'b1;
         5: evt[0].sweep_start <= 1'b1;
         default: evt[0].width_tick <= 1'b1;
      endcase
      @(posedge clk);
      evt[0] <= '{continuous: evt[0].continuous, default: 1'b0};
      repeat (4) @(posedge clk);
      ttl_mod[0] <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : stim

   task automatic pin(input logic ped);
      @(posedge clk);
      fire_in    <= ~ped;
      fire_pedal <= ped;
      @(posedge clk);
      fire_in    <= 1'b0;
      fire_pedal <= 1'b0;
      repeat (10) @(posedge clk);
   endtask : pin

   task automatic test_reset;
      rd(4'h0);
      chk(rd_v, 32'h0000_0100, "chan reset");
      rd(4'h4);
      chk(rd_v, 32'h0000_0001, "mode reset");
      rd(4'h5);
      chk(rd_v, 32'h0000_0000, "foot reset");
      rd(4'hA);
      chk(rd_v, 32'h0000_0000, "unmapped");
      $display("test_reset done");
   endtask : test_reset

   task automatic test_select;
      for (int c = 0; c < 8; c++)
      begin
         wr(4'h0, 32'h0000_0100 | c);
         n_fire = 0;
         for (int k = 0; k < 6; k++)
            stim(k);
         chk(n_fire, c >= 1 && c <= 6, "select");
      end
      evt[0].continuous <= 1'b1;
      wr(4'h0, 32'h0000_0104);
      n_fire = 0;
      stim(3);
      chk(n_fire, 0, "no step in sweep");
      stim(6);
      chk(n_fire, 1, "width tick");
      evt[0].continuous <= 1'b0;
      $display("test_select done");
   endtask : test_select

   task automatic test_rearm;
      wr(4'h0, 32'h0000_0001);
      n_fire = 0;
      stim(0);
      stim(0);
      chk(n_fire, 1, "no rearm");
      rd(4'h0);
      chk(rd_v, 32'h0000_0001, "disarmed");
      wr(4'h6, 32'h0000_0001);
      rd(4'h0);
      chk(rd_v[8], 1'b1, "local rearm");
      wr(4'h7, 32'h0000_0001);
      rd(4'h7);
      chk(rd_v, 32'h0000_0001, "dual read");
      wr(4'h0, 32'h0000_0102);
      wr(4'h1, 32'h0000_0005);
      rd(4'h1);
      chk(rd_v, 32'h0001_0102, "slave mirror");
      rd(4'h8);
      chk(rd_v, 32'h0000_0003, "armed status");
      n_fire1 = 0;
      @(posedge clk);
      evt[1].avg_start <= 1'b1;
      @(posedge clk);
      evt[1].avg_start <= 1'b0;
      repeat (4) @(posedge clk);
      chk(n_fire1, 1, "slave fires");
      wr(4'h7, 32'h0000_0000);
      $display("test_rearm done");
   endtask : test_rearm

   task automatic test_modes;
      wr(4'h0, 32'h0000_0101);
      for (int m = 0; m < 4; m++)
      begin
         wr(4'h4, m);
         n_slot = 0;
         seen0 = seen;
         pin(1'b0);
         chk(n_slot, mode_tbl[m][3], "pin slot");
         chk(seen - seen0, mode_tbl[m][2], "pin out");
         n_slot = 0;
         seen0 = seen;
         stim(0);
         chk(seen - seen0, mode_tbl[m][1], "evt out");
         chk(n_slot, mode_tbl[m][0], "evt loop");
      end
      wr(4'h4, 32'h0000_0001);
      n_slot = 0;
      pin(1'b1);
      chk(n_slot, 0, "pedal off");
      wr(4'h5, 32'h0000_0001);
      rd(4'h5);
      chk(rd_v, 32'h0000_0001, "foot read");
      n_slot = 0;
      pin(1'b1);
      chk(n_slot, 1, "pedal on");
      wr(4'h4, 32'h0000_0011);
      rd(4'h4);
      chk(rd_v[2:0], 3'h4, "custom read");
      n_slot = 0;
      seen0 = seen;
      pin(1'b0);
      chk(n_slot, 0, "custom idle");
      stim(0);
      chk(seen - seen0, 0, "custom out");
      $display("test_modes done");
   endtask : test_modes

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : print_verdict

   initial
   begin
      repeat (30000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end

   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      req = '0;
      evt = '0;
      ttl_mod = 4'h0;
      fire_in = 1'b0;
      fire_pedal = 1'b0;
      n_mismatch = 0;
      n_tests = 0;
      mode_tbl = '{4'h0, 4'hA, 4'hE, 4'hB};
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      test_reset();
      test_select();
      test_rearm();
      test_modes();
      print_verdict();
   end
endmodule : testbench
